// file: logic/nuel_pkg.sv
// Package with constants and types for the network unit error log
package nuel_pkg;
   localparam int unsigned DEPTH = 39;
   localparam int unsigned IDX_W = 6;
   localparam logic [IDX_W-1:0] IDX_LAST = 6'h26;
   localparam logic [IDX_W-1:0] IDX_ZERO = 6'h00;
   localparam logic [IDX_W-1:0] IDX_ONE  = 6'h01;
   localparam logic [IDX_W-1:0] CNT_FULL = 6'h27;
   localparam int unsigned REC_BYTES = 10;
   localparam int unsigned REC_W = 80;
   localparam int unsigned CODE_W = 16;
   localparam int unsigned TIME_W = 48;
   localparam logic [CODE_W-1:0] EC_WDT       = 16'h0001;
   localparam logic [CODE_W-1:0] EC_SVC_MON   = 16'h0002;
   localparam logic [CODE_W-1:0] EC_BUS_ID    = 16'h0004;
   localparam logic [CODE_W-1:0] EC_CPU_UNIT  = 16'h0006;
   localparam logic [CODE_W-1:0] EC_IO_BUS    = 16'h000E;
   localparam logic [CODE_W-1:0] EC_INIT      = 16'h000F;
   localparam logic [CODE_W-1:0] EC_SETUP_CAP = 16'h0010;
   localparam logic [CODE_W-1:0] EC_INIT_TO   = 16'h0011;
   localparam logic [CODE_W-1:0] DETAIL_ZERO  = 16'h0000;
   localparam logic [TIME_W-1:0] TIME_ZERO    = 48'h000000000000;
   localparam int unsigned BIT_HW_TEST_UNIT = 12;
   localparam int unsigned BIT_BAD_UNIT_NUM = 13;
   localparam logic [7:0] RESP_RELAY_ERR = 8'h05;
   localparam int unsigned RESP_SUB_NO_NODE = 2;
   localparam int unsigned NV_ADDR_W = 6;
   localparam logic [NV_ADDR_W-1:0] NV_LAST = 6'h26;
   localparam logic [NV_ADDR_W-1:0] NV_ZERO = 6'h00;
   localparam logic [NV_ADDR_W-1:0] NV_ONE  = 6'h01;

   typedef enum logic [1:0] {
      NUEL_RESTORE = 2'b00,
      NUEL_RUN     = 2'b01
   } nuel_state_t;

   typedef struct packed {
      logic [CODE_W-1:0] code;
      logic [CODE_W-1:0] detail;
      logic [TIME_W-1:0] stamp;
   } nuel_rec_t;

   // Kind of host fault reported on the fault strobe
   typedef enum logic [2:0] {
      NUEL_F_WDT   = 3'h0,
      NUEL_F_SVC   = 3'h1,
      NUEL_F_BUSID = 3'h2,
      NUEL_F_CPU   = 3'h3,
      NUEL_F_IOBUS = 3'h4,
      NUEL_F_INIT  = 3'h5,
      NUEL_F_SETUP = 3'h6,
      NUEL_F_INITO = 3'h7
   } nuel_fault_t;
endpackage

// file: logic/nuel_rec_if.sv
// Interface carrying a new record from the encoder to the log
`timescale 1ns/1ps
interface nuel_rec_if;
   import nuel_pkg::*;
   logic      valid;
   nuel_rec_t rec;
   logic      persist;
   modport src (output valid, output rec, output persist);
   modport dst (input valid, input rec, input persist);
endinterface

// file: logic/nuel_encode.sv
// Fault encoder: builds error code, detail and timestamp of a record
`timescale 1ns/1ps
module nuel_encode
   import nuel_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_n_i,
   // Fault event
   input  wire logic              fault_i,
   input  wire nuel_fault_t       kind_i,
   input  wire logic [CODE_W-1:0] detail_i,
   // Host time
   input  wire logic              time_ok_i,
   input  wire logic [TIME_W-1:0] time_i,
   // Record out
   nuel_rec_if.src                rec_o
);
   nuel_rec_t nxt_rec;
   logic      nxt_persist;

   always_comb begin
      nxt_rec.detail = DETAIL_ZERO;
      nxt_persist    = 1'b1;
      unique case (kind_i)
         NUEL_F_WDT:   nxt_rec.code = EC_WDT;
         NUEL_F_SVC: begin
            nxt_rec.code   = EC_SVC_MON;
            nxt_rec.detail = detail_i;
         end
         NUEL_F_BUSID: nxt_rec.code = EC_BUS_ID;
         NUEL_F_CPU: begin
            nxt_rec.code   = EC_CPU_UNIT;
            nxt_rec.detail = detail_i;
         end
         NUEL_F_IOBUS: nxt_rec.code = EC_IO_BUS;
         NUEL_F_INIT:  nxt_rec.code = EC_INIT;
         NUEL_F_SETUP: nxt_rec.code = EC_SETUP_CAP;
         NUEL_F_INITO: nxt_rec.code = EC_INIT_TO;
      endcase
      nxt_rec.stamp = time_ok_i ? time_i : TIME_ZERO;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rec_o.valid   <= 1'b0;
         rec_o.rec     <= '0;
         rec_o.persist <= 1'b0;
      end else begin
         rec_o.valid   <= fault_i;
         rec_o.rec     <= nxt_rec;
         rec_o.persist <= fault_i & nxt_persist;
      end
   end
endmodule // nuel_encode

// file: logic/nuel_relay.sv
// Relay error reporter for commands that cannot be forwarded
`timescale 1ns/1ps
module nuel_relay
   import nuel_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   // Forward attempt
   input  wire logic       fwd_req_i,
   input  wire logic       dest_present_i,
   input  wire logic       next_present_i,
   input  wire logic [7:0] src_node_i,
   // Response to source
   output logic            relay_err_o,
   output logic [7:0]      relay_node_o,
   output logic [7:0]      relay_resp_o
);
   logic fail;
   assign fail = fwd_req_i & ~(dest_present_i & next_present_i);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         relay_err_o  <= 1'b0;
         relay_node_o <= 8'h00;
         relay_resp_o <= 8'h00;
      end else begin
         relay_err_o <= fail;
         if (fail) begin
            relay_node_o <= src_node_i;
            relay_resp_o <= RESP_RELAY_ERR | 8'(RESP_SUB_NO_NODE);
         end
      end
   end
endmodule // nuel_relay

// file: logic/nuel_top.sv
// Error log table with nonvolatile copy, restore, read and clear
`timescale 1ns/1ps
// Contract
// - Report relay error when node absent
// - Return relay error and response to source
// - Volatile log holds at most 39 records
// - Record is ten bytes, time in BCD
// - Error code, detail code, then timestamp
// - Records ordered oldest first, newest last
// - Full log drops oldest, appends new
// - Significant errors copied to nonvolatile store; code copies errors of every kind
// - Power-up reloads nonvolatile records into log
// - Time bytes year month day hour sec min
// - Missing host time gives zero stamp
// - Log read and cleared by messages
// - Watchdog timeout code 0001, detail zero
// - Service monitor code 0002, detail ms
// - Bus unit id error code 0004
// - CPU unit error 0006, unit bits
// - Init 000F, timeout 0011, bus 000E
// - Setup over capacity code 0010
module nuel_top
   import nuel_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_n_i,
   // Host fault events
   input  wire logic              fault_i,
   input  wire nuel_fault_t       kind_i,
   input  wire logic [CODE_W-1:0] detail_i,
   input  wire logic              time_ok_i,
   input  wire logic [TIME_W-1:0] time_i,
   // Relay path
   input  wire logic              fwd_req_i,
   input  wire logic              dest_present_i,
   input  wire logic              next_present_i,
   input  wire logic [7:0]        src_node_i,
   output logic                   relay_err_o,
   output logic [7:0]             relay_node_o,
   output logic [7:0]             relay_resp_o,
   // Message service access
   input  wire logic              rd_req_i,
   input  wire logic [IDX_W-1:0]  rd_idx_i,
   input  wire logic              clr_req_i,
   output logic                   rd_valid_o,
   output logic [REC_W-1:0]       rd_rec_o,
   output logic [IDX_W-1:0]       count_o,
   output logic                   ready_o,
   // Nonvolatile store port
   output logic                   nv_wr_o,
   output logic [NV_ADDR_W-1:0]   nv_addr_o,
   output logic [REC_W-1:0]       nv_wdata_o,
   output logic                   nv_rd_o,
   input  wire logic [REC_W-1:0]  nv_rdata_i,
   input  wire logic              nv_rvalid_i,
   input  wire logic [IDX_W-1:0]  nv_count_i
);
   nuel_rec_if rec_bus ();

   nuel_encode u_encode (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .fault_i   (fault_i),
      .kind_i    (kind_i),
      .detail_i  (detail_i),
      .time_ok_i (time_ok_i),
      .time_i    (time_i),
      .rec_o     (rec_bus.src)
   );

   nuel_relay u_relay (
      .sys_clk_i      (sys_clk_i),
      .rst_n_i        (rst_n_i),
      .fwd_req_i      (fwd_req_i),
      .dest_present_i (dest_present_i),
      .next_present_i (next_present_i),
      .src_node_i     (src_node_i),
      .relay_err_o    (relay_err_o),
      .relay_node_o   (relay_node_o),
      .relay_resp_o   (relay_resp_o)
   );

   logic [REC_W-1:0]     table_ff [DEPTH];
   logic [IDX_W-1:0]     head_ff;
   logic [IDX_W-1:0]     count_ff;
   logic [NV_ADDR_W-1:0] nv_head_ff;
   logic                 rs_wait_ff;
   logic [IDX_W-1:0]     rs_left_ff;
   logic                 rs_pend_ff;
   nuel_state_t          state_ff;
   logic                 push;
   logic [REC_W-1:0]     push_rec;
   logic [IDX_W-1:0]     tail;
   logic [IDX_W-1:0]     rd_phys;
   logic [IDX_W:0]       sum_t;
   logic [IDX_W:0]       sum_r;

   function automatic logic [IDX_W-1:0] wrap(input logic [IDX_W:0] v);
      wrap = (v >= (IDX_W+1)'(DEPTH)) ? IDX_W'(v - (IDX_W+1)'(DEPTH)) : v[IDX_W-1:0];
   endfunction

   always_comb begin
      sum_t   = {1'b0, head_ff} + {1'b0, count_ff};
      sum_r   = {1'b0, head_ff} + {1'b0, rd_idx_i};
      tail    = wrap(sum_t);
      rd_phys = wrap(sum_r);
   end

   always_comb begin
      push     = 1'b0;
      push_rec = rec_bus.rec;
      if (state_ff == NUEL_RESTORE) begin
         push     = nv_rvalid_i;
         push_rec = nv_rdata_i;
      end else begin
         push = rec_bus.valid;
      end
   end

   // Restore sequencing
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_ff   <= NUEL_RESTORE;
         rs_left_ff <= IDX_ZERO;
         rs_pend_ff <= 1'b1;
      end else if (state_ff == NUEL_RESTORE) begin
         if (rs_pend_ff) begin
            rs_pend_ff <= 1'b0;
            rs_left_ff <= (nv_count_i > CNT_FULL) ? CNT_FULL : nv_count_i;
            if (nv_count_i == IDX_ZERO) begin
               state_ff <= NUEL_RUN;
            end
         end else if (nv_rvalid_i) begin
            rs_left_ff <= rs_left_ff - IDX_ONE;
            if (rs_left_ff == IDX_ONE) begin
               state_ff <= NUEL_RUN;
            end
         end
      end
   end

   // One store read outstanding; a repeated request would restart its latency
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rs_wait_ff <= 1'b0;
      end else if (nv_rd_o) begin
         rs_wait_ff <= 1'b1;
      end else if (nv_rvalid_i) begin
         rs_wait_ff <= 1'b0;
      end
   end

   // Nonvolatile read requests during restore
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         nv_rd_o <= 1'b0;
      end else begin
         nv_rd_o <= (state_ff == NUEL_RESTORE) && !rs_pend_ff && (rs_left_ff != IDX_ZERO)
                    && !nv_rd_o && !rs_wait_ff && !nv_rvalid_i;
      end
   end

   // Table storage
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         table_ff[(count_ff == CNT_FULL) ? head_ff : tail] <= push_rec;
      end
   end

   // Head and count
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         head_ff  <= IDX_ZERO;
         count_ff <= IDX_ZERO;
      end else if (push) begin
         if (count_ff == CNT_FULL) begin
            head_ff <= (head_ff == IDX_LAST) ? IDX_ZERO : head_ff + IDX_ONE;
         end else begin
            count_ff <= count_ff + IDX_ONE;
         end
         if (clr_req_i && state_ff == NUEL_RUN) begin
            head_ff  <= tail;
            count_ff <= IDX_ONE;
            if (count_ff == CNT_FULL) begin
               head_ff <= head_ff;
            end
         end
      end else if (clr_req_i && state_ff == NUEL_RUN) begin
         head_ff  <= IDX_ZERO;
         count_ff <= IDX_ZERO;
      end
   end

   // Nonvolatile ring writes
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         nv_wr_o    <= 1'b0;
         nv_addr_o  <= NV_ZERO;
         nv_wdata_o <= '0;
         nv_head_ff <= NV_ZERO;
      end else begin
         nv_wr_o <= 1'b0;
         if (state_ff == NUEL_RUN && rec_bus.valid && rec_bus.persist) begin
            nv_wr_o    <= 1'b1;
            nv_addr_o  <= nv_head_ff;
            nv_wdata_o <= rec_bus.rec;
            nv_head_ff <= (nv_head_ff == NV_LAST) ? NV_ZERO : nv_head_ff + NV_ONE;
         end
      end
   end

   // Read port and status
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rd_valid_o <= 1'b0;
         rd_rec_o   <= '0;
         count_o    <= IDX_ZERO;
         ready_o    <= 1'b0;
      end else begin
         rd_valid_o <= rd_req_i && (state_ff == NUEL_RUN) && (rd_idx_i < count_ff);
         if (rd_req_i && (rd_idx_i < count_ff)) begin
            rd_rec_o <= table_ff[rd_phys];
         end
         count_o <= count_ff;
         ready_o <= (state_ff == NUEL_RUN);
      end
   end
endmodule // nuel_top

// file: tb/nuel_top_asserts.sv
// Port-level assertions for the error log top module
`timescale 1ns/1ps
module nuel_top_asserts
   import nuel_pkg::*;
(
   // Clock, reset and faults
   input wire logic              sys_clk_i,
   input wire logic              rst_n_i,
   input wire logic              fault_i,
   input wire nuel_fault_t       kind_i,
   input wire logic [CODE_W-1:0] detail_i,
   input wire logic              time_ok_i,
   // Relay path
   input wire logic              fwd_req_i,
   input wire logic              dest_present_i,
   input wire logic              next_present_i,
   input wire logic [7:0]        src_node_i,
   input wire logic              relay_err_o,
   input wire logic [7:0]        relay_node_o,
   input wire logic [7:0]        relay_resp_o,
   // Log access and store reads and writes
   input wire logic              rd_req_i,
   input wire logic [IDX_W-1:0]  rd_idx_i,
   input wire logic              clr_req_i,
   input wire logic              rd_valid_o,
   input wire logic [IDX_W-1:0]  count_o,
   input wire logic              ready_o,
   input wire logic              nv_wr_o,
   input wire logic              nv_rd_o,
   input wire logic [REC_W-1:0]  nv_wdata_o
);
   default clocking dc @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_relay_fail: assert property (
      fwd_req_i && !(dest_present_i && next_present_i) |=> relay_err_o
      && relay_node_o == $past(src_node_i) && relay_resp_o == 8'h07)
      else $error("relay failure not reported");
   chk_count_cap: assert property (
      count_o <= 6'h27)
      else $error("record count above limit");
   chk_wdt_persist: assert property (
      fault_i && ready_o && kind_i == NUEL_F_WDT
      |-> ##2 nv_wr_o && nv_wdata_o[79:48] == 32'h0001_0000)
      else $error("watchdog record not stored");
   chk_svc_detail: assert property (
      fault_i && ready_o && kind_i == NUEL_F_SVC
      |-> ##2 nv_wr_o && nv_wdata_o[79:48] == {16'h0002, $past(detail_i, 2)})
      else $error("monitor record wrong");
   chk_stamp_zero: assert property (
      fault_i && ready_o && !time_ok_i |-> ##2 nv_wdata_o[47:0] == 48'h0)
      else $error("stamp not zero without time");
   chk_full_hold: assert property (
      count_o == 6'h27 && !clr_req_i && !$past(clr_req_i) ##1 !clr_req_i
      |=> count_o == 6'h27)
      else $error("full log lost a record");
   chk_rd_refuse: assert property (
      rd_req_i && rd_idx_i >= count_o ##1 $stable(count_o) |-> !rd_valid_o)
      else $error("read beyond count answered");
   chk_rd_answer: assert property (
      rd_req_i && ready_o && rd_idx_i < count_o ##1 $stable(count_o) |-> rd_valid_o)
      else $error("read not answered");
   chk_nv_rd_once: assert property (
      nv_rd_o |=> !nv_rd_o [*2])
      else $error("store read repeated while pending");
endmodule // nuel_top_asserts

bind nuel_top nuel_top_asserts u_chk (.*);

// file: tb/nuel_nv_model.sv
// Nonvolatile record store model on the far side of the log
`timescale 1ns/1ps
module nuel_nv_model
   import nuel_pkg::*;
#(
   parameter int LAT = 1
)
(
   // Clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_n_i,
   // Store port
   input  wire logic                 wr_i,
   input  wire logic [NV_ADDR_W-1:0] addr_i,
   input  wire logic [REC_W-1:0]     wdata_i,
   input  wire logic                 rd_i,
   output logic [REC_W-1:0]          rdata_o,
   output logic                      rvalid_o,
   output logic [IDX_W-1:0]          count_o
);
   logic [REC_W-1:0] mem [DEPTH];
   int               wp = 0;
   int               rp = 0;
   int               cnt = 0;
   int               dly = 0;
   assign count_o = IDX_W'(cnt);
   initial begin
      rdata_o = '0;
      rvalid_o = 1'b0;
   end
   always @(posedge sys_clk_i) begin
      rvalid_o <= 1'b0;
      // Data is not held once the answer is gone
      rdata_o <= ~rdata_o;
      if (!rst_n_i) begin
         rp <= (wp + 39 - cnt) % 39;
         dly <= 0;
      end else begin
         if (wr_i) begin
            mem[addr_i] <= wdata_i;
            wp <= (int'(addr_i) + 1) % 39;
            cnt <= (cnt < 39) ? cnt + 1 : cnt;
         end
         if (rd_i) dly <= LAT;
         else if (dly > 0) dly <= dly - 1;
         if (dly == 1) begin
            rvalid_o <= 1'b1;
            rdata_o <= mem[rp];
            rp <= (rp + 1) % 39;
         end
      end
   end
endmodule // nuel_nv_model

// file: tb/testbench.sv
// Self-checking bench for the error log
`timescale 1ns/1ps
module testbench
   import nuel_pkg::*;
;
   localparam logic [TIME_W-1:0] TS = 48'h250314095930;
   // Fault kind, detail in, expected code and detail
   logic [50:0] rows [8] = '{
      {NUEL_F_WDT, 16'hFFFF, 32'h0001_0000},
      {NUEL_F_SVC, 16'h01F4, 32'h0002_01F4},
      {NUEL_F_BUSID, 16'hABCD, 32'h0004_0000},
      {NUEL_F_CPU, 16'h3000, 32'h0006_3000},
      {NUEL_F_IOBUS, 16'h1234, 32'h000E_0000},
      {NUEL_F_INIT, 16'h5555, 32'h000F_0000},
      {NUEL_F_SETUP, 16'h0F0F, 32'h0010_0000},
      {NUEL_F_INITO, 16'h7777, 32'h0011_0000}
   };
   logic              sys_clk_i = 1'b0;
   logic              rst_n_i = 1'b0;
   logic              fault_i = 1'b0;
   nuel_fault_t       kind_i = NUEL_F_WDT;
   logic [CODE_W-1:0] detail_i = 16'h0000;
   logic              time_ok_i = 1'b1;
   logic [TIME_W-1:0] time_i = TS;
   logic              fwd_req_i = 1'b0;
   logic              dest_present_i = 1'b1;
   logic              next_present_i = 1'b1;
   logic [7:0]        src_node_i = 8'h00;
   logic              rd_req_i = 1'b0;
   logic [IDX_W-1:0]  rd_idx_i = 6'h00;
   logic              clr_req_i = 1'b0;
   logic              relay_err_o, rd_valid_o, ready_o, nv_wr_o, nv_rd_o, nv_rvalid_i;
   logic [7:0]        relay_node_o, relay_resp_o;
   logic [IDX_W-1:0]  count_o, nv_count_i, nv_addr_o;
   logic [REC_W-1:0]  rd_rec_o, nv_wdata_o, nv_rdata_i;
   logic [REC_W-1:0]  exp_q [$];
   logic [REC_W-1:0]  nv_q [$];
   int                err_total = 0;
   int                checked = 0;
   int                cyc = 0;

   nuel_top uut (.*);
   nuel_nv_model #(.LAT(3)) u_nv (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .wr_i      (nv_wr_o),
      .addr_i    (nv_addr_o),
      .wdata_i   (nv_wdata_o),
      .rd_i      (nv_rd_o),
      .rdata_o   (nv_rdata_i),
      .rvalid_o  (nv_rvalid_i),
      .count_o   (nv_count_i)
   );

   always #12.5 sys_clk_i = ~sys_clk_i;

   task automatic finish_test();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(string nm, logic [REC_W-1:0] e, logic [REC_W-1:0] s);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic push(nuel_fault_t k, logic [CODE_W-1:0] d, logic [REC_W-1:0] e);
      @(negedge sys_clk_i);
      fault_i = 1'b1;
      kind_i = k;
      detail_i = d;
      @(negedge sys_clk_i);
      fault_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      if (exp_q.size() == 39) void'(exp_q.pop_front());
      if (nv_q.size() == 39) void'(nv_q.pop_front());
      exp_q.push_back(e);
      nv_q.push_back(e);
   endtask

   task automatic rd(logic [IDX_W-1:0] i, logic v, logic [REC_W-1:0] e);
      @(negedge sys_clk_i);
      rd_req_i = 1'b1;
      rd_idx_i = i;
      @(negedge sys_clk_i);
      rd_req_i = 1'b0;
      chk("rd_valid_o", v, rd_valid_o);
      if (v) chk("rd_rec_o", e, rd_rec_o);
   endtask

   task automatic check_all();
      chk("count_o", exp_q.size(), count_o);
      foreach (exp_q[i]) rd(IDX_W'(i), 1'b1, exp_q[i]);
      rd(IDX_W'(exp_q.size()), 1'b0, '0);
   endtask

   task automatic wait_rdy();
      for (int i = 0; i < 2000 && ready_o !== 1'b1; i++) @(negedge sys_clk_i);
      chk("ready_o", 1, ready_o);
   endtask

   initial begin
      repeat (10) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      wait_rdy();
      foreach (rows[i]) begin
         push(nuel_fault_t'(rows[i][50:48]), rows[i][47:32], {rows[i][31:0], TS});
      end
      check_all();
      time_ok_i = 1'b0;
      push(NUEL_F_INIT, 16'h0000, {32'h000F_0000, 48'h0});
      time_ok_i = 1'b1;
      for (int n = 0; n < 34; n++) begin
         push(NUEL_F_SVC, 16'(n), {16'h0002, 16'(n), TS});
      end
      check_all();
      @(negedge sys_clk_i);
      clr_req_i = 1'b1;
      @(negedge sys_clk_i);
      clr_req_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      exp_q.delete();
      chk("count_o", 0, count_o);
      push(NUEL_F_CPU, 16'h2000, {32'h0006_2000, TS});
      check_all();
      for (int c = 0; c < 3; c++) begin
         @(negedge sys_clk_i);
         fwd_req_i = 1'b1;
         dest_present_i = (c != 0);
         next_present_i = (c != 1);
         src_node_i = 8'h40 + 8'(c);
         @(negedge sys_clk_i);
         fwd_req_i = 1'b0;
         chk("relay_err_o", c != 2, relay_err_o);
         if (c != 2) chk("relay_resp", {8'h07, 8'h40 + 8'(c)}, {relay_resp_o, relay_node_o});
      end
      @(negedge sys_clk_i);
      rst_n_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      exp_q = nv_q;
      wait_rdy();
      check_all();
      finish_test();
   end
endmodule // testbench
